//--- logic/etas_serial.sv
// event-paced asynchronous serial transfer server with apb registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module etas_serial import etas_pkg::*; #(
  parameter int TW = 16
) (
  input  wire logic        sysClk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  portIn,
  output logic [7:0]       portOut,
  output logic             eventIrq,
  output logic             eotIrq
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  count;
    logic [7:0]  initCount;
    logic [15:0] data;
    logic [7:0]  portOut;
    logic [7:0]  mask;
    logic [7:0]  spacing;
    logic [7:0]  spaceCnt;
    logic        firstSamp;
    logic        evtFlag;
    logic        eotFlag;
    logic        frameErr;
    logic        parErr;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] rxWord;
    etas_svst_t  st;
  } etas_st_t;
  etas_st_t q, d;

  logic [TW-1:0] timer, evTime;
  logic          tick, match, capt;
  logic          lineIn;
  logic          fifoReady, fifoValid, fifoPop;
  logic [15:0]   fifoData;
  logic          setup, commit, bitVal, wrTime;

  // received word right-justified, stop bit at index n-1
  function automatic logic [15:0] justify(input logic [15:0] w, input logic [7:0] n);
    logic [4:0] sh;
    sh = (n >= 8'(ETAS_MAX_BITS)) ? 5'd0 : 5'(ETAS_MAX_BITS - int'(n));
    return w >> sh;
  endfunction

  function automatic logic parityOf(input logic [15:0] w, input logic [7:0] n);
    logic [15:0] m;
    m = (n >= 8'h02) ? ((16'h0001 << (n - 8'h01)) - 16'h0001) : 16'h0000;
    return ^(w & m);
  endfunction

  assign lineIn = |(portIn & q.mask);
  assign setup  = psel && !penable;
  assign wrTime = psel && penable && q.pready && pwrite && paddr == ETAS_OFF_EVTIME;
  assign fifoPop = psel && penable && q.pready && !pwrite && paddr == ETAS_OFF_RXFIFO;

  etas_event_chan #(.TW(TW)) u_evt (
    .sysClk    (sysClk),
    .nrst      (nrst),
    .captMode  (q.ctrl[ETAS_CTRL_CAPT]),
    .wrTime    (wrTime),
    .wrTimeVal (pwdata[TW-1:0]),
    .lineIn    (lineIn),
    .timer     (timer),
    .evTime    (evTime),
    .tick      (tick),
    .match     (match),
    .capt      (capt)
  );

  etas_fifo #(.W(16), .D(ETAS_FIFO_DEPTH)) u_rxq (
    .sysClk   (sysClk),
    .nrst     (nrst),
    .inValid  (q.st == SV_PUSH),
    .inData   (q.rxWord),
    .inReady  (fifoReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoPop)
  );

  always_comb begin
    logic        txMode;
    logic        svc;
    logic [15:0] w;
    logic [3:0]  hwSet;
    d = q;
    txMode = q.ctrl[ETAS_CTRL_TX];
    svc    = q.ctrl[ETAS_CTRL_SVCSEL];
    commit = 1'b0;
    bitVal = 1'b0;
    w      = '0;
    hwSet  = '0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // compare events without service and captures go to the conventional flag
    if (capt || (match && !svc)) begin
      d.evtFlag = 1'b1;
      hwSet[0]  = 1'b1;
    end

    unique case (q.st)
      SV_IDLE: begin
        if (match && svc && !q.ctrl[ETAS_CTRL_CAPT]) begin
          if (q.count == 8'h00) begin
            d.eotFlag = 1'b1;
            hwSet[1]  = 1'b1;
          end else if (txMode) begin
            bitVal = q.data[0];
            commit = 1'b1;
          end else if (q.ctrl[ETAS_CTRL_MAJ]) begin
            d.firstSamp = lineIn;
            d.spaceCnt  = q.spacing;
            d.st        = SV_WAIT2;
          end else begin
            bitVal = lineIn;
            commit = 1'b1;
          end
        end
      end
      SV_WAIT2, SV_WAIT3: begin
        if (tick) begin
          if (q.spaceCnt != 8'h00) begin
            d.spaceCnt = q.spaceCnt - 8'h01;
          end else if (q.st == SV_WAIT3 || lineIn == q.firstSamp) begin
            bitVal = lineIn;
            commit = 1'b1;
            d.st   = SV_IDLE;
          end else begin
            d.spaceCnt = q.spacing;
            d.st       = SV_WAIT3;
          end
        end
      end
      SV_PUSH: begin
        // received words wait here while the queue is full
        if (fifoReady) d.st = SV_IDLE;
      end
    endcase

    if (commit) begin
      d.data  = {txMode ? 1'b1 : bitVal, q.data[15:1]};
      d.count = q.count - 8'h01;
      if (txMode) d.portOut = (q.portOut & ~q.mask) | (q.mask & {8{bitVal}});
      if (q.count == 8'h01) begin
        d.eotFlag = 1'b1;
        hwSet[1]  = 1'b1;
        d.ctrl[ETAS_CTRL_SVCSEL] = 1'b0;
        if (!txMode) begin
          w = justify({bitVal, q.data[15:1]}, q.initCount);
          d.rxWord = w;
          d.st     = SV_PUSH;
          if (!bitVal) begin
            d.frameErr = 1'b1;
            hwSet[2]   = 1'b1;
          end
          if (q.ctrl[ETAS_CTRL_PAREN]
              && parityOf(w, q.initCount) != q.ctrl[ETAS_CTRL_PARODD]) begin
            d.parErr = 1'b1;
            hwSet[3] = 1'b1;
          end
        end
      end
    end

    // apb: registered answer, one access cycle
    if (setup) begin
      d.pready = 1'b1;
      d.prdata = '0;
      unique case (paddr)
        ETAS_OFF_CTRL:   d.prdata = {24'h000000, q.ctrl};
        ETAS_OFF_COUNT:  d.prdata = {24'h000000, q.count};
        ETAS_OFF_EVTIME: d.prdata = 32'(evTime);
        ETAS_OFF_TIMER:  d.prdata = 32'(timer);
        ETAS_OFF_DATA:   d.prdata = {16'h0000, q.data};
        ETAS_OFF_PORT:   d.prdata = {16'h0000, portIn, q.portOut};
        ETAS_OFF_MASK:   d.prdata = {24'h000000, q.mask};
        ETAS_OFF_SPACE:  d.prdata = {24'h000000, q.spacing};
        ETAS_OFF_STATUS: d.prdata = {27'h0000000, fifoValid, q.parErr, q.frameErr,
                                     q.eotFlag, q.evtFlag};
        ETAS_OFF_RXFIFO: d.prdata = {16'h0000, fifoData};
        default:         d.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && q.pready && pwrite) begin
      unique case (paddr)
        ETAS_OFF_CTRL:  d.ctrl = pwdata[7:0];
        ETAS_OFF_COUNT: begin
          d.count     = pwdata[7:0];
          d.initCount = pwdata[7:0];
        end
        ETAS_OFF_DATA:  d.data = pwdata[15:0];
        ETAS_OFF_PORT:  d.portOut = pwdata[7:0];
        ETAS_OFF_MASK:  d.mask = pwdata[7:0];
        ETAS_OFF_SPACE: d.spacing = pwdata[7:0];
        ETAS_OFF_STATUS: begin
          // write one to clear; a same-cycle hardware set wins
          d.evtFlag  = (q.evtFlag & ~pwdata[ETAS_ST_EVT]) | hwSet[0];
          d.eotFlag  = (q.eotFlag & ~pwdata[ETAS_ST_EOT]) | hwSet[1];
          d.frameErr = (q.frameErr & ~pwdata[ETAS_ST_FRAME]) | hwSet[2];
          d.parErr   = (q.parErr & ~pwdata[ETAS_ST_PAR]) | hwSet[3];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sysClk) begin
    if (!nrst) begin
      q         <= '0;
      q.ctrl    <= ETAS_RST_CTRL;
      q.data    <= ETAS_RST_DATA;
      q.portOut <= ETAS_RST_PORT;
      q.mask    <= ETAS_RST_MASK;
      q.spacing <= ETAS_RST_SPACE;
      q.st      <= SV_IDLE;
    end else begin
      q <= d;
    end
  end

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign portOut  = q.portOut;
  assign eventIrq = q.evtFlag;
  assign eotIrq   = q.eotFlag;

  default clocking @(posedge sysClk); endclocking
  default disable iff (!nrst);
  a_eot_last_bit: assert property (commit && q.count == 8'h01 |=> eotIrq)
    else $error("last bit did not raise end of transfer");
  a_count_down: assert property (commit |=> q.count == $past(q.count) - 8'h01)
    else $error("bit count not decremented");
  a_tx_lsb_out: assert property (commit && q.ctrl[ETAS_CTRL_TX]
                                 |=> (|(portOut & q.mask)) == $past(q.data[0]))
    else $error("transmit bit is not the data lsb");
  a_rx_shift_in: assert property (commit && !q.ctrl[ETAS_CTRL_TX]
                                  |=> q.data[15] == $past(bitVal))
    else $error("sampled bit not shifted in");
  a_capt_no_svc: assert property (capt |-> !commit ##1 eventIrq)
    else $error("capture did not raise the conventional flag");
  a_maj_third: assert property (q.st == SV_WAIT2 && tick && q.spaceCnt == 8'h00
                                && lineIn != q.firstSamp |=> q.st == SV_WAIT3)
    else $error("disagreeing samples did not take a third");
  a_maj_spacing: assert property ($rose(q.st == SV_WAIT2) |-> q.spaceCnt == q.spacing)
    else $error("sample spacing not loaded");
  a_frame_err: assert property (commit && !q.ctrl[ETAS_CTRL_TX] && q.count == 8'h01
                                && !bitVal |=> q.frameErr)
    else $error("low stop bit did not flag framing error");
  a_tx_len_max: assert property (commit && q.ctrl[ETAS_CTRL_TX] |=> q.data[15])
    else $error("transmit fill is not idle high");
  c_tx_word: cover property (commit && q.ctrl[ETAS_CTRL_TX] && q.count == 8'h01);
  c_rx_word: cover property (q.st == SV_PUSH ##1 q.st == SV_IDLE);
  c_third_sample: cover property (q.st == SV_WAIT3 && commit);
  c_fifo_stall: cover property (q.st == SV_PUSH && !fifoReady);
endmodule // etas_serial

//--- logic/etas_pkg.sv
// shared constants and types of the event-timed asynchronous serial block
package etas_pkg;
  // register byte offsets
  localparam logic [7:0] ETAS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ETAS_OFF_COUNT  = 8'h04;
  localparam logic [7:0] ETAS_OFF_EVTIME = 8'h08;
  localparam logic [7:0] ETAS_OFF_TIMER  = 8'h0C;
  localparam logic [7:0] ETAS_OFF_DATA   = 8'h10;
  localparam logic [7:0] ETAS_OFF_PORT   = 8'h14;
  localparam logic [7:0] ETAS_OFF_MASK   = 8'h18;
  localparam logic [7:0] ETAS_OFF_SPACE  = 8'h1C;
  localparam logic [7:0] ETAS_OFF_STATUS = 8'h20;
  localparam logic [7:0] ETAS_OFF_RXFIFO = 8'h24;
  // control field positions
  localparam int ETAS_CTRL_TX     = 0;
  localparam int ETAS_CTRL_SVCSEL = 1;
  localparam int ETAS_CTRL_CAPT   = 2;
  localparam int ETAS_CTRL_MAJ    = 3;
  localparam int ETAS_CTRL_PAREN  = 4;
  localparam int ETAS_CTRL_PARODD = 5;
  // status field positions
  localparam int ETAS_ST_EVT   = 0;
  localparam int ETAS_ST_EOT   = 1;
  localparam int ETAS_ST_FRAME = 2;
  localparam int ETAS_ST_PAR   = 3;
  localparam int ETAS_ST_RXVLD = 4;
  // reset values
  localparam logic [7:0]  ETAS_RST_CTRL  = 8'h00;
  localparam logic [7:0]  ETAS_RST_PORT  = 8'hFF;
  localparam logic [7:0]  ETAS_RST_MASK  = 8'h01;
  localparam logic [7:0]  ETAS_RST_SPACE = 8'h01;
  localparam logic [15:0] ETAS_RST_DATA  = 16'h0000;
  // longest word the server moves
  localparam int ETAS_MAX_BITS = 16;
  // timebase: timer tick every ETAS_TICK_CYC core cycles
  localparam int ETAS_CLK_HZ   = 40000000;
  localparam int ETAS_TICK_NS  = 250;
  localparam int ETAS_TICK_CYC = (ETAS_TICK_NS * (ETAS_CLK_HZ / 1000000)) / 1000;
  localparam int ETAS_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {SV_IDLE, SV_WAIT2, SV_WAIT3, SV_PUSH} etas_svst_t;
endpackage

//--- logic/etas_fifo.sv
// synchronous valid/ready fifo for received words
`timescale 1ns/1ps
module etas_fifo import etas_pkg::*; #(
  parameter int W = 16,
  parameter int D = ETAS_FIFO_DEPTH
) (
  input  wire logic         sysClk,
  input  wire logic         nrst,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } etas_fst_t;
  etas_fst_t q, d;
  logic [W-1:0] mem [D];
  logic push, pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = (q.cnt != (AW+1)'(D));
  assign outValid = (q.cnt != '0);
  assign outData  = mem[q.rp];

  always_comb begin
    d = q;
    if (push) d.wp = q.wp + 1'b1;
    if (pop) d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sysClk) begin
    if (!nrst) q <= '0;
    else q <= d;
    if (push) mem[q.wp] <= inData;
  end

  default clocking @(posedge sysClk); endclocking
  default disable iff (!nrst);
  a_fifo_full_stall: assert property (q.cnt == (AW+1)'(D) |-> !inReady)
    else $error("fifo accepts data while full");
endmodule // etas_fifo

//--- logic/etas_event_chan.sv
// timebase timer with one capture/compare event channel
`timescale 1ns/1ps
module etas_event_chan import etas_pkg::*; #(
  parameter int TW = 16
) (
  input  wire logic          sysClk,
  input  wire logic          nrst,
  input  wire logic          captMode,
  input  wire logic          wrTime,
  input  wire logic [TW-1:0] wrTimeVal,
  input  wire logic          lineIn,
  output logic [TW-1:0]      timer,
  output logic [TW-1:0]      evTime,
  output logic               tick,
  output logic               match,
  output logic               capt
);
  typedef struct packed {
    logic [7:0]    div;
    logic [TW-1:0] tmr;
    logic [TW-1:0] evt;
    logic          tick;
    logic          match;
    logic          capt;
    logic          lineLast;
  } etas_est_t;
  etas_est_t q, d;

  always_comb begin
    d = q;
    d.tick  = 1'b0;
    d.match = 1'b0;
    d.capt  = 1'b0;
    d.lineLast = lineIn;
    if (q.div == 8'(ETAS_TICK_CYC - 1)) begin
      d.div  = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 8'h01;
    end
    if (q.tick) begin
      d.tmr = q.tmr + 1'b1;
      if (!captMode && q.tmr == q.evt) d.match = 1'b1;
    end
    if (captMode && q.lineLast && !lineIn) begin
      d.capt = 1'b1;
      d.evt  = q.tmr;
    end
    if (wrTime) d.evt = wrTimeVal;
  end

  always_ff @(posedge sysClk) begin
    if (!nrst) q <= '0;
    else q <= d;
  end

  assign timer  = q.tmr;
  assign evTime = q.evt;
  assign tick   = q.tick;
  assign match  = q.match;
  assign capt   = q.capt;

  default clocking @(posedge sysClk); endclocking
  default disable iff (!nrst);
  a_match_raise: assert property (q.tick && !captMode && q.tmr == q.evt
                                  && !wrTime |=> match)
    else $error("compare equality did not raise a request");
  a_capture_edge: assert property (capt |-> $past(captMode) && $past(q.lineLast))
    else $error("capture without a falling edge in capture mode");
endmodule // etas_event_chan

//--- bench/etas_remote.sv
// remote serial device: sends frames on the receive line, decodes the transmit line
`timescale 1ns/1ps
module etas_remote #(
  parameter int BIT = 80
) (
  input  wire logic sysClk,
  input  wire logic txLine,
  output logic      rxLine
);
  logic [15:0] got;

  initial rxLine = 1'b1;

  // start bit low, then lsb first; the line idles high between frames
  task automatic send(input logic [15:0] w, input int n);
    rxLine <= 1'b0;
    repeat (BIT) @(posedge sysClk);
    for (int i = 0; i < n; i++) begin
      rxLine <= w[i];
      repeat (BIT) @(posedge sysClk);
    end
    rxLine <= 1'b1;
  endtask

  // samples mid-bit, timed from the falling start edge
  task automatic listen(input int n);
    got = 16'h0000;
    while (txLine !== 1'b0) @(posedge sysClk);
    repeat (BIT + BIT / 2) @(posedge sysClk);
    for (int i = 0; i < n; i++) begin
      got[i] = txLine;
      repeat (BIT) @(posedge sysClk);
    end
  endtask
endmodule // etas_remote

//--- bench/tb_etas_serial.sv
// testbench for the event-timed asynchronous serial block
`timescale 1ns/1ps
module tb_etas_serial import etas_pkg::*;;
  localparam int BIT = 8;
  localparam int H   = BIT * 3 / 2;
  logic        sysClk  = 1'b0;
  logic        nrst    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  portIn;
  logic [7:0]  portOut;
  logic        eventIrq;
  logic        eotIrq;
  logic        rxLine;
  logic        txLine;
  logic [2:0]  lane    = 3'h0;
  logic [31:0] rdat;
  logic        rerr;
  int          n_fail    = 0;
  int          cmp_count = 0;

  always #12.5 sysClk = ~sysClk;
  assign portIn = rxLine ? 8'hFF : ~(8'h01 << lane);
  assign txLine = portOut[lane];

  etas_serial etas_serial_inst (
    .sysClk(sysClk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portIn(portIn), .portOut(portOut), .eventIrq(eventIrq),
    .eotIrq(eotIrq)
  );
  etas_remote #(.BIT(BIT * ETAS_TICK_CYC)) etas_remote_inst (
    .sysClk(sysClk), .txLine(txLine), .rxLine(rxLine)
  );

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sysClk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sysClk);
    penable <= 1'b1;
    do @(posedge sysClk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk(rdat, e);
  endtask

  // rewrites the event time after each event but the last, since the channel does not advance it on its own
  task automatic pace(input logic [15:0] ev, input int n);
    for (int k = 1; k <= n; k++) begin
      rdat = 32'h0;
      while (rdat[15:0] <= ev) apb(1'b0, ETAS_OFF_TIMER, 32'h0, rdat, rerr);
      if (k < n) begin
        chk({31'h0, eotIrq}, 32'h0);
        ev = ev + 16'(BIT);
        wr(ETAS_OFF_EVTIME, {16'h0, ev});
      end
    end
  endtask

  task automatic waitEot(input logic [31:0] c);
    int n;
    n = 0;
    while (eotIrq !== 1'b1 && n < 300) begin
      @(posedge sysClk);
      n++;
    end
    chk({31'h0, eotIrq}, 32'h1);
    rchk(ETAS_OFF_CTRL, c);
  endtask

  task automatic tx_frame(input logic [15:0] w, input int n);
    logic [31:0] t;
    fork
      etas_remote_inst.listen(n);
      begin
        wr(ETAS_OFF_DATA, {16'h0, w});
        wr(ETAS_OFF_COUNT, 32'(n));
        wr(ETAS_OFF_PORT, 32'hFE);
        apb(1'b0, ETAS_OFF_TIMER, 32'h0, t, rerr);
        wr(ETAS_OFF_EVTIME, t + 32'(BIT));
        wr(ETAS_OFF_CTRL, 32'h3);
        pace(t[15:0] + 16'(BIT), n);
        waitEot(32'h1);
      end
    join
    chk({16'h0, etas_remote_inst.got}, {16'h0, w});
    wr(ETAS_OFF_STATUS, 32'hF);
  endtask

  task automatic rx_frame(input logic [15:0] w, input logic [31:0] c, input logic [2:0] ln,
                          input logic e, input logic [1:0] er);
    logic [31:0] t;
    int n;
    lane = ln;
    wr(ETAS_OFF_MASK, 32'h1 << ln);
    wr(ETAS_OFF_COUNT, 32'hA);
    wr(ETAS_OFF_DATA, 32'h0);
    wr(ETAS_OFF_CTRL, c | 32'h4);
    fork
      etas_remote_inst.send(w, 10);
      begin
        n = 0;
        while (eventIrq !== 1'b1 && n < 400) begin
          @(posedge sysClk);
          n++;
        end
        chk({eventIrq, eotIrq}, 32'h2);
        apb(1'b0, ETAS_OFF_CTRL, 32'h0, t, rerr);
        chk({31'h0, t[2]}, 32'h1);
        apb(1'b0, ETAS_OFF_EVTIME, 32'h0, t, rerr);
        wr(ETAS_OFF_EVTIME, t + 32'(H));
        wr(ETAS_OFF_STATUS, 32'h1);
        wr(ETAS_OFF_CTRL, c | 32'h2);
        pace(t[15:0] + 16'(H), 10);
        if (e) begin
          waitEot(c);
          apb(1'b0, ETAS_OFF_STATUS, 32'h0, t, rerr);
          chk({30'h0, t[3:2]}, {30'h0, er});
        end
      end
    join
    wr(ETAS_OFF_STATUS, 32'hF);
  endtask

  function automatic logic [15:0] frm(input logic [7:0] d);
    return {6'h0, 1'b1, ~^d, d};
  endfunction

  initial begin
    #(25 * 60000);
    n_fail++;
    stop_test;
  end

  initial begin
    repeat (6) @(posedge sysClk);
    nrst <= 1'b1;
    rchk(ETAS_OFF_CTRL, {24'h0, ETAS_RST_CTRL});
    rchk(ETAS_OFF_MASK, {24'h0, ETAS_RST_MASK});
    rchk(ETAS_OFF_SPACE, {24'h0, ETAS_RST_SPACE});
    rchk(ETAS_OFF_DATA, {16'h0, ETAS_RST_DATA});
    rchk(ETAS_OFF_PORT, 32'hFFFF);
    rchk(8'h28, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    tx_frame(16'h03A5, 10);
    tx_frame(16'hC35A, ETAS_MAX_BITS);
    // seventeenth word waits for room, so its end flag is not awaited
    for (int i = 0; i < 17; i++) begin
      rx_frame(frm(8'h30 + 8'(i)), {28'h3, i[0], 3'h0}, 3'h0, i < 16, 2'h0);
    end
    for (int i = 0; i < 17; i++) begin
      rchk(ETAS_OFF_RXFIFO, {16'h0, frm(8'h30 + 8'(i))});
    end
    wr(ETAS_OFF_STATUS, 32'hF);
    rchk(ETAS_OFF_STATUS, 32'h0);
    rx_frame(16'h00A5, 32'h30, 3'h2, 1'b1, 2'h3);
    rchk(ETAS_OFF_RXFIFO, 32'h00A5);
    stop_test;
  end
endmodule // tb_etas_serial
